// *** shared/decode_pkg.sv ***
// constants, types and decode functions for the instruction word decoder
// assumes a single core clock; opcode codes cover only what timing needs
package decode_pkg;
    localparam int WORD_W = 14;
    localparam int FILE_W = 7;
    localparam int BIT_W = 3;
    localparam int LIT_W = 8;
    localparam int TGT_W = 11;
    localparam int DATA_W = 8;
    localparam int CNT_W = 2;
    // timing: one instruction cycle is four oscillator cycles
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_PER_ICYC = 4;
    localparam int ICYC_NS = OSC_PER_ICYC * CLK_PERIOD_NS;
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
    localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
    localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
    localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;
    // field positions
    localparam int D_POS = 7;
    localparam int B_LSB = 7;
    localparam int SKIP_POL_POS = 10;
    localparam int N_UPD_POS = 2;
    localparam int N_OFS_POS = 6;
    // file addresses of the two indirect access ports
    localparam logic [FILE_W-1:0] IND_PORT0 = 7'h00;
    localparam logic [FILE_W-1:0] IND_PORT1 = 7'h01;
    localparam logic [CNT_W-1:0] ONE_CYC = 2'h1;
    localparam logic [CNT_W-1:0] TWO_CYC = 2'h2;

    typedef enum logic [1:0] {CL_BYTE, CL_BIT, CL_LIT} class_t;
    typedef enum logic [2:0] {
        OP_PLAIN, OP_CALL, OP_RET, OP_JUMP,
        OP_SKIPZ, OP_SKIPB, OP_PTRUPD, OP_PTROFS
    } op_t;

    // class from the top bits; words 00_0000_0xxx_xxxx are control
    function automatic class_t class_of(input logic [WORD_W-1:0] w);
        if (w[13:12] == 2'h1)
            return CL_BIT;
        if (w[13:12] == 2'h0 && w[13:7] != 7'h00)
            return CL_BYTE;
        return CL_LIT;
    endfunction

    // operation kind; ? positions are ignored whatever they hold
    function automatic op_t kind_of(input logic [WORD_W-1:0] w);
        casez (w)
            14'b00_0000_0000_100?: return OP_RET;
            14'b00_0000_0000_1010: return OP_CALL;
            14'b00_0000_0000_1011: return OP_JUMP;
            14'b00_0000_0001_????: return OP_PTRUPD;
            14'b00_1?11_????_????: return OP_SKIPZ;
            14'b01_1???_????_????: return OP_SKIPB;
            14'b10_0???_????_????: return OP_CALL;
            14'b10_1???_????_????: return OP_JUMP;
            14'b11_001?_????_????: return OP_JUMP;
            14'b11_0100_????_????: return OP_RET;
            14'b11_1111_0???_????: return OP_PTROFS;
            default: return OP_PLAIN;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] base_cycles(input op_t k);
        if (k == OP_CALL || k == OP_RET || k == OP_JUMP)
            return TWO_CYC;
        return ONE_CYC;
    endfunction
endpackage

// *** src/quarter_phase.sv ***
// four-phase sequencer dividing the core clock into instruction cycles
// assumes MCLK is the oscillator clock itself
`timescale 1ns/1ns
module quarter_phase
    import decode_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    output logic [PHASE_W-1:0] phase
);
    logic [PHASE_W-1:0] phase_d;

    // free-running count, one phase per rising oscillator edge
    always_comb begin
        phase_d = phase + PH_Q2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            phase <= PH_Q1;
        else
            phase <= phase_d;
    end
endmodule // quarter_phase

// *** src/word_fields.sv ***
// combinational split of one instruction word into class, kind, fields
// assumes the word is stable while it is being sampled
`timescale 1ns/1ns
module word_fields
    import decode_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    output class_t cls,
    output op_t kind,
    output logic [CNT_W-1:0] cycles,
    output logic names_file,
    output logic to_file,
    output logic to_acc,
    output logic [FILE_W-1:0] file_addr,
    output logic [BIT_W-1:0] bit_sel,
    output logic [LIT_W-1:0] literal,
    output logic [TGT_W-1:0] target,
    output logic ptr_sel,
    output logic [1:0] ptr_mode
);
    // field slicing and destination routing
    always_comb begin
        cls = class_of(word);
        kind = kind_of(word);
        cycles = base_cycles(kind);
        names_file = (cls != CL_LIT);
        file_addr = word[FILE_W-1:0];
        bit_sel = word[B_LSB+BIT_W-1:B_LSB];
        literal = word[LIT_W-1:0];
        target = word[TGT_W-1:0];
        // pointer number sits low for update, high for offset forms
        ptr_sel = (kind == OP_PTROFS) ? word[N_OFS_POS] : word[N_UPD_POS];
        ptr_mode = word[1:0];
        // byte ops follow d; bit set/clear always go back to the file
        to_file = (cls == CL_BYTE && word[D_POS]) ||
                  (cls == CL_BIT && kind != OP_SKIPB);
        to_acc = (cls == CL_BYTE && !word[D_POS]) ||
                 (cls == CL_LIT && word[13] &&
                  (kind == OP_PLAIN || kind == OP_RET));
    end
endmodule // word_fields

// *** src/instruction_word_decode_timing.sv ***
// instruction word decoder and instruction-cycle sequencer
// assumes the fetch stage and register file run on MCLK
// Summary of operation
// - every instruction is one 14-bit word holding opcode and operands.
// - words sort into byte, bit, and literal/control classes.
// - instructions finish in one instruction cycle unless listed below.
// - both subroutine calls take two instruction cycles.
// - subroutine returns, literal returns, interrupt returns take two.
// - jumps, branches and taken skips take two instruction cycles.
// - indirect access with pointer in program memory adds one cycle.
// - one instruction cycle is exactly four oscillator cycles.
// - a named file register is always read before it is written.
// - result goes where the instruction or the d field says.
// - d=0 sends result to accumulator, d=1 to file register.
// - file address selects 0x00 to 0x7F of the banked window.
// - bit select picks one bit of the 8-bit file register.
// - pointer select chooses indirect pointer 0 or 1.
// - don't-care bits do not change the decode.
// - two-bit mode picks pre/post increment or decrement.
// - byte words: d at bit 7, file address bits 6 to 0.
// - bit words: bit select bits 9 to 7, file address 6 to 0.
// - general literal words: 8-bit literal in bits 7 to 0.
// - call and jump words: 11-bit target in bits 10 to 0.
`timescale 1ns/1ns
module instruction_word_decode_timing
    import decode_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [WORD_W-1:0] WORD_IN,
    input wire logic WORD_VALID,
    output logic WORD_READY,
    output logic [PHASE_W-1:0] PHASE,
    output logic CYCLE_START,
    output class_t INSTR_CLASS,
    output op_t OP_KIND,
    output logic DEST_FILE,
    output logic [FILE_W-1:0] FILE_ADDR,
    output logic [BIT_W-1:0] BIT_SEL,
    output logic [LIT_W-1:0] LITERAL,
    output logic [TGT_W-1:0] TARGET,
    output logic PTR_SEL,
    output logic [1:0] PTR_MODE,
    output logic PTR_PRE,
    output logic PTR_DOWN,
    input wire logic [1:0] PTR_IN_PROG,
    output logic RF_RD_EN,
    output logic [FILE_W-1:0] RF_RD_ADDR,
    input wire logic [DATA_W-1:0] RF_RD_DATA,
    input wire logic [DATA_W-1:0] MOD_DATA,
    output logic RF_WR_EN,
    output logic [FILE_W-1:0] RF_WR_ADDR,
    output logic [DATA_W-1:0] RF_WR_DATA,
    output logic ACC_WE,
    output logic [DATA_W-1:0] ACC_DATA,
    output logic INSTR_DONE,
    output logic [CNT_W-1:0] INSTR_CYCLES
);
    import decode_pkg::*;

    typedef enum logic {ST_IDLE, ST_EXEC} state_t;

    logic [PHASE_W-1:0] ph;
    class_t w_cls;
    op_t w_kind;
    logic [CNT_W-1:0] w_cyc;
    logic w_names, w_file, w_acc, w_psel;
    logic [FILE_W-1:0] w_addr;
    logic [BIT_W-1:0] w_bit;
    logic [LIT_W-1:0] w_lit;
    logic [TGT_W-1:0] w_tgt;
    logic [1:0] w_mode;
    logic w_ind;

    state_t state_q, state_d;
    class_t cls_q, cls_d;
    op_t kind_q, kind_d;
    logic names_q, names_d;
    logic file_q, file_d;
    logic acc_q, acc_d;
    logic first_q, first_d;
    logic ind_q, ind_d;
    logic pol_q, pol_d;
    logic psel_q, psel_d;
    logic [1:0] mode_q, mode_d;
    logic [FILE_W-1:0] addr_q, addr_d;
    logic [BIT_W-1:0] bit_q, bit_d;
    logic [LIT_W-1:0] lit_q, lit_d;
    logic [TGT_W-1:0] tgt_q, tgt_d;
    logic [CNT_W-1:0] left_q, left_d;
    logic [CNT_W-1:0] total_q, total_d;
    logic [DATA_W-1:0] res_q, res_d;
    logic take, skip_hit, last;

    quarter_phase u_phase (
        .clk(MCLK),
        .rst(RST),
        .phase(ph)
    );

    word_fields u_fields (
        .word(WORD_IN),
        .cls(w_cls),
        .kind(w_kind),
        .cycles(w_cyc),
        .names_file(w_names),
        .to_file(w_file),
        .to_acc(w_acc),
        .file_addr(w_addr),
        .bit_sel(w_bit),
        .literal(w_lit),
        .target(w_tgt),
        .ptr_sel(w_psel),
        .ptr_mode(w_mode)
    );

    // indirect port whose pointer currently points into program memory
    assign w_ind = w_names && ((w_addr == IND_PORT0 && PTR_IN_PROG[0]) ||
                   (w_addr == IND_PORT1 && PTR_IN_PROG[1]));

    // a new word is taken only at Q1 once the previous one is spent
    assign last = (state_q == ST_IDLE) || (left_q == '0);
    assign WORD_READY = (ph == PH_Q1) && last;
    assign take = WORD_READY && WORD_VALID;

    // skip test on the value fetched at Q2, seen at Q3
    always_comb begin
        skip_hit = 1'b0;
        if (kind_q == OP_SKIPZ)
            skip_hit = (MOD_DATA == '0);
        else if (kind_q == OP_SKIPB)
            skip_hit = (RF_RD_DATA[bit_q] == pol_q);
    end

    // sequencer: latch on take, count instruction cycles, modify at Q3
    always_comb begin
        state_d = state_q;
        cls_d = cls_q;
        kind_d = kind_q;
        names_d = names_q;
        file_d = file_q;
        acc_d = acc_q;
        first_d = first_q;
        ind_d = ind_q;
        pol_d = pol_q;
        psel_d = psel_q;
        mode_d = mode_q;
        addr_d = addr_q;
        bit_d = bit_q;
        lit_d = lit_q;
        tgt_d = tgt_q;
        left_d = left_q;
        total_d = total_q;
        res_d = res_q;
        if (take) begin
            state_d = ST_EXEC;
            cls_d = w_cls;
            kind_d = w_kind;
            names_d = w_names;
            file_d = w_file;
            acc_d = w_acc;
            first_d = 1'b1;
            ind_d = w_ind;
            pol_d = WORD_IN[SKIP_POL_POS];
            psel_d = w_psel;
            mode_d = w_mode;
            addr_d = w_addr;
            bit_d = w_bit;
            lit_d = w_lit;
            tgt_d = w_tgt;
            // base time plus the program-memory indirection penalty
            total_d = w_cyc + CNT_W'(w_ind);
            left_d = total_d - ONE_CYC;
        end else if (ph == PH_Q1 && state_q == ST_EXEC) begin
            if (left_q != '0) begin
                left_d = left_q - ONE_CYC;
                first_d = 1'b0;
            end else begin
                state_d = ST_IDLE;
                first_d = 1'b0;
            end
        end else if (ph == PH_Q3 && state_q == ST_EXEC && first_q) begin
            res_d = MOD_DATA;
            // taken skip discards the next word: one more cycle
            if (skip_hit) begin
                left_d = left_q + ONE_CYC;
                total_d = total_q + ONE_CYC;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            cls_q <= CL_LIT;
            kind_q <= OP_PLAIN;
            names_q <= 1'b0;
            file_q <= 1'b0;
            acc_q <= 1'b0;
            first_q <= 1'b0;
            ind_q <= 1'b0;
            pol_q <= 1'b0;
            psel_q <= 1'b0;
            mode_q <= 2'h0;
            addr_q <= '0;
            bit_q <= '0;
            lit_q <= '0;
            tgt_q <= '0;
            left_q <= '0;
            total_q <= '0;
            res_q <= '0;
        end else begin
            state_q <= state_d;
            cls_q <= cls_d;
            kind_q <= kind_d;
            names_q <= names_d;
            file_q <= file_d;
            acc_q <= acc_d;
            first_q <= first_d;
            ind_q <= ind_d;
            pol_q <= pol_d;
            psel_q <= psel_d;
            mode_q <= mode_d;
            addr_q <= addr_d;
            bit_q <= bit_d;
            lit_q <= lit_d;
            tgt_q <= tgt_d;
            left_q <= left_d;
            total_q <= total_d;
            res_q <= res_d;
        end
    end

    // phase outputs, then decoded fields straight from the latched word
    assign PHASE = ph;
    assign CYCLE_START = (ph == PH_Q1);
    assign INSTR_CLASS = cls_q;
    assign OP_KIND = kind_q;
    assign DEST_FILE = file_q;
    assign FILE_ADDR = addr_q;
    assign BIT_SEL = bit_q;
    assign LITERAL = lit_q;
    assign TARGET = tgt_q;
    assign PTR_SEL = psel_q;
    assign PTR_MODE = mode_q;
    assign PTR_PRE = !mode_q[1];
    assign PTR_DOWN = mode_q[0];

    // read at Q2 whenever a file is named, even for pure writes
    assign RF_RD_EN = (state_q == ST_EXEC) && first_q && names_q &&
                      (ph == PH_Q2);
    assign RF_RD_ADDR = addr_q;
    // write-back at Q4, after the read of the same cycle
    assign RF_WR_EN = (state_q == ST_EXEC) && first_q && file_q &&
                      (ph == PH_Q4);
    assign RF_WR_ADDR = addr_q;
    assign RF_WR_DATA = res_q;
    assign ACC_WE = (state_q == ST_EXEC) && first_q && acc_q &&
                    (ph == PH_Q4);
    assign ACC_DATA = res_q;
    // done marks Q4 of the final instruction cycle
    assign INSTR_DONE = (state_q == ST_EXEC) && (left_q == '0) &&
                        (ph == PH_Q4);
    assign INSTR_CYCLES = total_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    chk_phase_period: assert property (
        (ph == PH_Q1) |=> (ph != PH_Q1) [*3] ##1 (ph == PH_Q1))
        else $error("instruction cycle is not four clocks");
    chk_read_first: assert property (
        RF_WR_EN |-> $past(RF_RD_EN, 2) && $past(RF_RD_ADDR, 2) == RF_WR_ADDR)
        else $error("file write without a prior read");
    chk_dest_route: assert property (
        (take && w_cls == CL_BYTE) |=> DEST_FILE == $past(WORD_IN[D_POS]))
        else $error("destination select misrouted");
    chk_byte_fields: assert property (
        take |=> FILE_ADDR == $past(WORD_IN[6:0]) && BIT_SEL ==
        $past(WORD_IN[9:7]) && TARGET == $past(WORD_IN[10:0]))
        else $error("operand fields wrongly sliced");
    chk_plain_one: assert property (
        (INSTR_DONE && OP_KIND == OP_PLAIN && !ind_q) |-> INSTR_CYCLES == 1)
        else $error("plain instruction not one cycle");
    chk_call_two: assert property (
        (take && w_kind == OP_CALL && !w_ind) |->
        ##1 (!INSTR_DONE) [*6] ##1 INSTR_DONE)
        else $error("call not two cycles");
    chk_ret_two: assert property (
        (INSTR_DONE && OP_KIND == OP_RET && !ind_q) |-> INSTR_CYCLES == 2)
        else $error("return not two cycles");
    chk_skip_taken: assert property (
        (ph == PH_Q3 && first_q && state_q == ST_EXEC && skip_hit &&
        !ind_q) |-> ##1 (!INSTR_DONE) [*4] ##1 INSTR_DONE)
        else $error("taken skip not two cycles");
    chk_ind_extra: assert property (
        (take && w_ind && w_kind == OP_PLAIN) |=> INSTR_CYCLES == 2)
        else $error("indirect penalty missing");
    chk_ready_q1: assert property (
        WORD_READY |-> ph == PH_Q1 && (state_q == ST_IDLE || left_q == 0))
        else $error("word taken outside Q1");
endmodule // instruction_word_decode_timing

// *** bench/rf_model.sv ***
// register file and datapath stand-in on the decoder's operand side
// assumes reads are answered one clock after the read strobe
`timescale 1ns/1ns
module rf_model (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [7:0] mod_data,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem [128];

    // each cell starts as its address with bit 7 set
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = {1'b1, i[6:0]};
        end
        rd_data = 8'h00;
    end

    // outside the answer cycle invert the previous output every clock, so stale data returns every other clock
    always @(posedge clk) begin
        rd_data <= rd_en ? mem[rd_addr] : ~rd_data;
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // datapath stand-in: modified value is the read value plus one
    assign mod_data = rd_data + 8'h01;
endmodule // rf_model

// *** bench/tb.sv ***
// self-checking bench for the instruction word decoder
// assumes the operand model answers reads and the bench acts as fetch
`timescale 1ns/1ns
module tb;
    import decode_pkg::*;
    logic MCLK, RST, WORD_VALID, WORD_READY, CYCLE_START, DEST_FILE;
    logic PTR_SEL, PTR_PRE, PTR_DOWN, RF_RD_EN, RF_WR_EN, ACC_WE;
    logic INSTR_DONE;
    logic [13:0] WORD_IN;
    logic [1:0] PHASE, PTR_MODE, PTR_IN_PROG, INSTR_CYCLES;
    logic [6:0] FILE_ADDR, RF_RD_ADDR, RF_WR_ADDR;
    logic [2:0] BIT_SEL;
    logic [7:0] LITERAL, RF_RD_DATA, MOD_DATA, RF_WR_DATA, ACC_DATA;
    logic [10:0] TARGET;
    class_t INSTR_CLASS;
    op_t OP_KIND;
    int fail_count = 0, comparisons = 0, n, rd_at, wr_at, acc_at;
    logic [7:0] wdat, adat;

    instruction_word_decode_timing u_instruction_word_decode_timing (
        .MCLK(MCLK), .RST(RST), .WORD_IN(WORD_IN),
        .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY), .PHASE(PHASE),
        .CYCLE_START(CYCLE_START), .INSTR_CLASS(INSTR_CLASS),
        .OP_KIND(OP_KIND), .DEST_FILE(DEST_FILE), .FILE_ADDR(FILE_ADDR),
        .BIT_SEL(BIT_SEL), .LITERAL(LITERAL), .TARGET(TARGET),
        .PTR_SEL(PTR_SEL), .PTR_MODE(PTR_MODE), .PTR_PRE(PTR_PRE),
        .PTR_DOWN(PTR_DOWN), .PTR_IN_PROG(PTR_IN_PROG),
        .RF_RD_EN(RF_RD_EN), .RF_RD_ADDR(RF_RD_ADDR),
        .RF_RD_DATA(RF_RD_DATA), .MOD_DATA(MOD_DATA), .RF_WR_EN(RF_WR_EN),
        .RF_WR_ADDR(RF_WR_ADDR), .RF_WR_DATA(RF_WR_DATA), .ACC_WE(ACC_WE),
        .ACC_DATA(ACC_DATA), .INSTR_DONE(INSTR_DONE),
        .INSTR_CYCLES(INSTR_CYCLES));

    rf_model u_rf_model (
        .clk(MCLK), .rd_en(RF_RD_EN), .rd_addr(RF_RD_ADDR),
        .rd_data(RF_RD_DATA), .mod_data(MOD_DATA), .wr_en(RF_WR_EN),
        .wr_addr(RF_WR_ADDR), .wr_data(RF_WR_DATA));

    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    // wide enough for three packed counters, so nothing is cut off
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen,
                exp);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // offer one word, hold it until taken, then log strobes until done
    task automatic run(input logic [13:0] w, input logic [1:0] pin);
        int k;
        @(posedge MCLK);
        WORD_IN <= w;
        WORD_VALID <= 1'b1;
        PTR_IN_PROG <= pin;
        k = 0;
        do begin
            @(negedge MCLK);
            k++;
        end while (!(WORD_READY === 1'b1 && PHASE === 2'h0) && k < 40);
        check(WORD_READY === 1'b1 && PHASE === 2'h0, 1'b1);
        @(posedge MCLK);
        WORD_VALID <= 1'b0;
        n = 0;
        rd_at = 0;
        wr_at = 0;
        acc_at = 0;
        do begin
            @(negedge MCLK);
            n++;
            if (RF_RD_EN === 1'b1)
                rd_at = n;
            if (RF_WR_EN === 1'b1) begin
                wr_at = n;
                wdat = RF_WR_DATA;
            end
            if (ACC_WE === 1'b1) begin
                acc_at = n;
                adat = ACC_DATA;
            end
        end while (INSTR_DONE !== 1'b1 && n < 20);
        check(INSTR_DONE, 1'b1);
    endtask

    task automatic t_phase();
        logic [1:0] p;
        @(negedge MCLK);
        p = PHASE;
        repeat (8) begin
            @(negedge MCLK);
            p = p + 2'h1;
            check(PHASE, p);
            check(CYCLE_START, p == 2'h0);
        end
    endtask

    task automatic t_byte();
        run(14'h07FE, 2'h0);
        check(INSTR_CLASS, CL_BYTE);
        check(FILE_ADDR, 7'h7E);
        check(DEST_FILE, 1'b1);
        check(n, 3);
        check({rd_at, wr_at, acc_at}, {32'd1, 32'd3, 32'd0});
        check(wdat, 8'hFF);
        check({RF_RD_ADDR, RF_WR_ADDR}, {7'h7E, 7'h7E});
        check(INSTR_CYCLES, 2'h1);
        run(14'h0705, 2'h0);
        check({rd_at, wr_at, acc_at}, {32'd1, 32'd0, 32'd3});
        check(adat, 8'h86);
        run(14'h00A0, 2'h0);
        check({rd_at, wr_at}, {32'd1, 32'd3});
    endtask

    task automatic t_bit();
        run(14'h17B3, 2'h0);
        check({INSTR_CLASS, BIT_SEL, FILE_ADDR}, {CL_BIT, 3'h7, 7'h33});
        run(14'h1444, 2'h0);
        check({BIT_SEL, FILE_ADDR}, {3'h0, 7'h44});
    endtask

    task automatic t_lit();
        run(14'h3EA5, 2'h0);
        check({INSTR_CLASS, LITERAL}, {CL_LIT, 8'hA5});
        check({n, rd_at, acc_at}, {32'd3, 32'd0, 32'd3});
    endtask

    task automatic t_two();
        logic [13:0] ws [8] = '{14'h27FF, 14'h2C00, 14'h000A, 14'h000B,
            14'h0008, 14'h0009, 14'h3442, 14'h3255};
        foreach (ws[i]) begin
            run(ws[i], 2'h0);
            check(n, 7);
            check(INSTR_CYCLES, 2'h2);
            if (i < 2)
                check(TARGET, i == 0 ? 11'h7FF : 11'h400);
        end
    endtask

    task automatic t_skip();
        logic [13:0] ws [7] = '{14'h0B7F, 14'h0B10, 14'h0F7F, 14'h1E10,
            14'h1C90, 14'h1890, 14'h1A10};
        int ex [7] = '{7, 3, 7, 7, 3, 7, 3};
        foreach (ws[i]) begin
            run(ws[i], 2'h0);
            check(n, ex[i]);
        end
    endtask

    task automatic t_ind();
        run(14'h0701, 2'h2);
        check(n, 7);
        check(INSTR_CYCLES, 2'h2);
        run(14'h0701, 2'h1);
        check(n, 3);
        run(14'h0700, 2'h1);
        check(n, 7);
    endtask

    task automatic t_ptr();
        logic [1:0] mm;
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                mm = m[1:0];
                run({11'h002, s[0], mm}, 2'h0);
                check({OP_KIND, PTR_SEL, PTR_MODE}, {OP_PTRUPD, s[0], mm});
                check({PTR_PRE, PTR_DOWN}, {~mm[1], mm[0]});
            end
        end
        run(14'h3F55, 2'h0);
        check(PTR_SEL, 1'b1);
        run(14'h3F15, 2'h0);
        check(PTR_SEL, 1'b0);
    endtask

    task automatic t_dontcare();
        logic [31:0] a;
        run(14'h0100, 2'h0);
        a = {INSTR_CLASS, OP_KIND, DEST_FILE, n[3:0]};
        check(a, {CL_BYTE, OP_PLAIN, 1'b0, 4'h3});
        run(14'h0103, 2'h0);
        check({INSTR_CLASS, OP_KIND, DEST_FILE, n[3:0]}, a);
    endtask

    // word held valid: count completions over four instruction cycles
    task automatic t_b2b(input logic [13:0] w, input int exp);
        int cnt;
        do @(negedge MCLK); while (PHASE !== 2'h3);
        @(posedge MCLK);
        WORD_IN <= w;
        WORD_VALID <= 1'b1;
        cnt = 0;
        repeat (16) begin
            @(negedge MCLK);
            if (INSTR_DONE === 1'b1)
                cnt++;
        end
        @(posedge MCLK);
        WORD_VALID <= 1'b0;
        check(cnt, exp);
    endtask

    // hang guard: the whole sequence needs well under 1500 clocks
    initial begin
        #(3000 * 50);
        fail_count++;
        summarize();
    end

    initial begin
        RST = 1'b1;
        WORD_VALID = 1'b0;
        WORD_IN = 14'h0000;
        PTR_IN_PROG = 2'h0;
        repeat (8) @(posedge MCLK);
        @(negedge MCLK);
        check({PHASE, WORD_READY, OP_KIND}, {2'h0, 1'b1, OP_PLAIN});
        @(posedge MCLK);
        RST <= 1'b0;
        t_phase();
        t_byte();
        t_bit();
        t_lit();
        t_two();
        t_skip();
        t_ind();
        t_ptr();
        t_dontcare();
        t_b2b(14'h3EA5, 4);
        t_b2b(14'h27FF, 2);
        summarize();
    end
endmodule // tb
